// File: cal_regs_pkg.sv
// Constants and types for the upper-channel calibration and configuration registers
package cal_regs_pkg;

   // ----------------------------------------------------------------
   // Register access geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W   = 6;
   localparam int DATA_W   = 16;
   localparam int CAL_W    = 24;
   localparam int NUM_REGS = 7;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [5:0] ADDR_CH4_OFFSET_LOW_BYTE  = 6'h1F;
   localparam logic [5:0] ADDR_CH4_GAIN_HIGH_WORD   = 6'h20;
   localparam logic [5:0] ADDR_CH4_GAIN_LOW_BYTE    = 6'h21;
   localparam logic [5:0] ADDR_CH5_CHANNEL_CONFIG   = 6'h22;
   localparam logic [5:0] ADDR_CH5_OFFSET_HIGH_WORD = 6'h23;
   localparam logic [5:0] ADDR_CH5_OFFSET_LOW_BYTE  = 6'h24;
   localparam logic [5:0] ADDR_CH5_GAIN_HIGH_WORD   = 6'h25;

   // ----------------------------------------------------------------
   // Reset values and writable-bit masks
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_ZERO       = 16'h0000;
   localparam logic [15:0] RST_UNITY_GAIN = 16'h8000;
   localparam logic [15:0] MASK_FULL      = 16'hFFFF;
   localparam logic [15:0] MASK_LOW_BYTE  = 16'hFF00;
   localparam logic [15:0] MASK_CONFIG    = 16'hFFC7;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int LOW_BITS_MSB = 15;
   localparam int LOW_BITS_LSB = 8;
   localparam int PHASE_MSB    = 15;
   localparam int PHASE_LSB    = 6;
   localparam int PHASE_W      = 10;
   localparam int DC_OFF_BIT   = 2;
   localparam int SEL_MSB      = 1;
   localparam int SEL_LSB      = 0;

   // ----------------------------------------------------------------
   // Register table indices
   // ----------------------------------------------------------------
   localparam int IDX_CH4_OFS_LO = 0;
   localparam int IDX_CH4_GAIN_HI = 1;
   localparam int IDX_CH4_GAIN_LO = 2;
   localparam int IDX_CH5_CHANNEL_CONFIG     = 3;
   localparam int IDX_CH5_OFS_HI  = 4;
   localparam int IDX_CH5_OFS_LO  = 5;
   localparam int IDX_CH5_GAIN_HI = 6;

   localparam logic [5:0] REG_ADDR [0:NUM_REGS-1] = '{
      ADDR_CH4_OFFSET_LOW_BYTE, ADDR_CH4_GAIN_HIGH_WORD, ADDR_CH4_GAIN_LOW_BYTE,
      ADDR_CH5_CHANNEL_CONFIG, ADDR_CH5_OFFSET_HIGH_WORD, ADDR_CH5_OFFSET_LOW_BYTE,
      ADDR_CH5_GAIN_HIGH_WORD};
   localparam logic [15:0] REG_RESET [0:NUM_REGS-1] = '{
      RST_ZERO, RST_UNITY_GAIN, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_UNITY_GAIN};
   localparam logic [15:0] REG_MASK [0:NUM_REGS-1] = '{
      MASK_LOW_BYTE, MASK_FULL, MASK_LOW_BYTE, MASK_CONFIG, MASK_FULL, MASK_LOW_BYTE,
      MASK_FULL};

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SEL_OWN_PINS = 2'h0,
      SEL_SHORTED  = 2'h1,
      SEL_TEST_POS = 2'h2,
      SEL_TEST_NEG = 2'h3
   } input_sel_t;

   typedef struct packed {
      logic own_pins;
      logic shorted;
      logic test_pos;
      logic test_neg;
   } input_route_t;

   typedef struct packed {
      logic [23:0] offset;
      logic [23:0] gain;
   } cal_word_t;

   typedef struct packed {
      logic [9:0] phase_delay;
      logic       dc_filter_en;
   } ch_cfg_t;

endpackage

// File: cal_reg16.sv
// One 16-bit register with reset value and writable-bit mask
`timescale 1ns/1ps
module cal_reg16 #(
   parameter logic [15:0] RESET_VAL  = 16'h0000,
   parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
   // Clock and control
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ce_i,
   // Write port
   input  wire logic        wr_i,
   input  wire logic [15:0] wdata_i,
   // Stored value
   output logic      [15:0] q_o
);

   logic [15:0] val_reg;
   logic [15:0] val_next;

   // Masked bits never take write data and stay zero
   assign val_next = wr_i ? (wdata_i & WRITE_MASK) : val_reg;
   assign q_o      = val_reg;

   // Storage
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         val_reg <= RESET_VAL & WRITE_MASK;
      end else if (ce_i) begin
         val_reg <= val_next;
      end
   end

endmodule // cal_reg16

// File: adc_channel_cal_cfg_regs.sv
// Channel four and five calibration and configuration register slice
`timescale 1ns/1ps
// Summary of operation
// - Ch4 offset low byte sits in bits 15:8; bits 7:0 read zero.
// - Ch4 gain high word at 20h, resets to 8000h (unity).
// - Ch4 gain high word holds gain bits 23:8, all sixteen writable.
// - Gain is unsigned fraction, 0.0 to just under 2.0.
// - Ch4 gain low byte at 21h, reset zero, low byte reserved.
// - Ch5 config at 22h, reset zero, bits 5:3 read zero.
// - Ch5 config bits 15:6 hold signed phase delay.
// - Ch5 bit 2 clear follows global DC filter; set disables it.
// - Ch5 input select: own pins, shorted, positive or negative test.
// - Ch5 offset high word at 23h, reset zero, bits 23:8.
// - Ch5 offset low byte at 24h, reset zero, low byte reserved.
// - Ch5 gain high word at 25h, resets to 8000h.
module adc_channel_cal_cfg_regs (
   // Clock, reset, enable
   input  wire logic                     clk_i,
   input  wire logic                     sys_rst_i,
   input  wire logic                     ce_i,
   // Register access port from the serial interface
   input  wire logic [cal_regs_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic                     reg_wr_i,
   input  wire logic                     reg_rd_i,
   input  wire logic [cal_regs_pkg::DATA_W-1:0] reg_wdata_i,
   output logic      [cal_regs_pkg::DATA_W-1:0] reg_rdata_o,
   output logic                          reg_rd_valid_o,
   output logic                          reg_hit_o,
   // Neighbouring register fields held elsewhere
   input  wire logic [15:0]              ch4_offset_high_bits_i,
   input  wire logic [7:0]               ch5_gain_low_bits_i,
   input  wire logic                     global_dc_filter_setting_i,
   // Signal path controls
   output cal_regs_pkg::cal_word_t       ch4_cal_o,
   output cal_regs_pkg::cal_word_t       ch5_cal_o,
   output cal_regs_pkg::ch_cfg_t         ch5_channel_config_o,
   output cal_regs_pkg::input_route_t    ch5_input_route_o
);
   import cal_regs_pkg::*;

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [15:0]         reg_q  [0:NUM_REGS-1];
   logic [NUM_REGS-1:0] wr_sel;
   logic [NUM_REGS-1:0] addr_hit;

   // Address decode and one register per table entry
   for (genvar i = 0; i < NUM_REGS; i++) begin : g_regs
      assign addr_hit[i] = (reg_addr_i == REG_ADDR[i]);
      assign wr_sel[i]   = reg_wr_i & addr_hit[i];
      cal_reg16 #(
         .RESET_VAL  (REG_RESET[i]),
         .WRITE_MASK (REG_MASK[i])
      ) u_reg (
         .clk_i     (clk_i),
         .sys_rst_i (sys_rst_i),
         .ce_i      (ce_i),
         .wr_i      (wr_sel[i]),
         .wdata_i   (reg_wdata_i),
         .q_o       (reg_q[i])
      );
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [15:0] rd_mux;
   logic        any_hit;
   logic [15:0] rdata_reg;
   logic        rd_valid_reg;
   logic        hit_reg;

   assign any_hit = |addr_hit;

   // Read multiplexer, unmapped addresses return zero
   always_comb begin
      rd_mux = 16'h0000;
      for (int k = 0; k < NUM_REGS; k++) begin
         if (addr_hit[k]) begin
            rd_mux = reg_q[k];
         end
      end
   end

   // Registered read answer
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_reg    <= 16'h0000;
         rd_valid_reg <= 1'b0;
         hit_reg      <= 1'b0;
      end else if (ce_i) begin
         rdata_reg    <= reg_rd_i ? rd_mux : rdata_reg;
         rd_valid_reg <= reg_rd_i;
         hit_reg      <= reg_rd_i ? any_hit : hit_reg;
      end
   end

   assign reg_rdata_o    = rdata_reg;
   assign reg_rd_valid_o = rd_valid_reg;
   assign reg_hit_o      = hit_reg;

   // ----------------------------------------------------------------
   // Field extraction and derived controls
   // ----------------------------------------------------------------
   logic [15:0]  cfg5;
   input_sel_t   sel5;
   cal_word_t    ch4_cal_next;
   cal_word_t    ch5_cal_next;
   ch_cfg_t      ch5_channel_config_next;
   input_route_t route_next;

   assign cfg5 = reg_q[IDX_CH5_CHANNEL_CONFIG];
   assign sel5 = input_sel_t'(cfg5[SEL_MSB:SEL_LSB]);

   // Joining high words above low bytes, from the low registers' upper bytes or, for ch5 gain, ch5_gain_low_bits_i
   assign ch4_cal_next.offset = {ch4_offset_high_bits_i,
                                 reg_q[IDX_CH4_OFS_LO][LOW_BITS_MSB:LOW_BITS_LSB]};
   assign ch4_cal_next.gain   = {reg_q[IDX_CH4_GAIN_HI],
                                 reg_q[IDX_CH4_GAIN_LO][LOW_BITS_MSB:LOW_BITS_LSB]};
   assign ch5_cal_next.offset = {reg_q[IDX_CH5_OFS_HI],
                                 reg_q[IDX_CH5_OFS_LO][LOW_BITS_MSB:LOW_BITS_LSB]};
   assign ch5_cal_next.gain   = {reg_q[IDX_CH5_GAIN_HI], ch5_gain_low_bits_i};

   // Phase delay and DC filter gating
   assign ch5_channel_config_next.phase_delay  = cfg5[PHASE_MSB:PHASE_LSB];
   assign ch5_channel_config_next.dc_filter_en = global_dc_filter_setting_i
                                      & ~cfg5[DC_OFF_BIT];

   // Input select decoded one-hot
   assign route_next.own_pins = (sel5 == SEL_OWN_PINS);
   assign route_next.shorted  = (sel5 == SEL_SHORTED);
   assign route_next.test_pos = (sel5 == SEL_TEST_POS);
   assign route_next.test_neg = (sel5 == SEL_TEST_NEG);

   cal_word_t    ch4_cal_reg;
   cal_word_t    ch5_cal_reg;
   ch_cfg_t      ch5_channel_config_reg;
   input_route_t route_reg;

   // Output registers toward the signal path
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ch4_cal_reg <= '{offset: 24'h00_0000, gain: {RST_UNITY_GAIN, 8'h00}};
         ch5_cal_reg <= '{offset: 24'h00_0000, gain: {RST_UNITY_GAIN, 8'h00}};
         ch5_channel_config_reg <= '{phase_delay: 10'h000, dc_filter_en: 1'b0};
         route_reg   <= '{own_pins: 1'b1, shorted: 1'b0, test_pos: 1'b0, test_neg: 1'b0};
      end else if (ce_i) begin
         ch4_cal_reg <= ch4_cal_next;
         ch5_cal_reg <= ch5_cal_next;
         ch5_channel_config_reg <= ch5_channel_config_next;
         route_reg   <= route_next;
      end
   end

   assign ch4_cal_o         = ch4_cal_reg;
   assign ch5_cal_o         = ch5_cal_reg;
   assign ch5_channel_config_o         = ch5_channel_config_reg;
   assign ch5_input_route_o = route_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // Clock enable of the previous cycle, for the freeze check
   logic ce_prev_reg;
   always_ff @(posedge clk_i) begin
      ce_prev_reg <= ce_i;
   end

   AST_CH4_OFS_LOW_RSVD: assert property (reg_q[IDX_CH4_OFS_LO][7:0] == 8'h00)
      else $error("ch4 offset low reserved bits not zero");
   AST_CH4_GAIN_RESET: assert property (
      $past(sys_rst_i) |-> (reg_q[IDX_CH4_GAIN_HI] == RST_UNITY_GAIN))
      else $error("ch4 gain high word reset value wrong");
   AST_CH4_GAIN_WRITE: assert property (
      (ce_i && reg_wr_i && reg_addr_i == ADDR_CH4_GAIN_HIGH_WORD)
      |=> (reg_q[IDX_CH4_GAIN_HI] == $past(reg_wdata_i)))
      else $error("ch4 gain high word write lost");
   AST_CH4_GAIN_LOW: assert property (
      (ce_i && reg_wr_i && reg_addr_i == ADDR_CH4_GAIN_LOW_BYTE)
      |=> (reg_q[IDX_CH4_GAIN_LO] == {$past(reg_wdata_i[15:8]), 8'h00}))
      else $error("ch4 gain low byte write wrong");
   AST_CH4_GAIN_JOIN: assert property (
      ce_i |=> (ch4_cal_o.gain == {$past(reg_q[IDX_CH4_GAIN_HI]),
                                   $past(reg_q[IDX_CH4_GAIN_LO][15:8])}))
      else $error("ch4 gain word not joined");
   AST_CH5_CHANNEL_CONFIG_RSVD: assert property (cfg5[5:3] == 3'h0)
      else $error("ch5 config reserved bits not zero");
   AST_CH5_PHASE: assert property (
      (ce_i && reg_wr_i && reg_addr_i == ADDR_CH5_CHANNEL_CONFIG) ##1 ce_i
      |=> (ch5_channel_config_o.phase_delay == $past(reg_wdata_i[15:6], 2)))
      else $error("ch5 phase delay not passed on");
   AST_CH5_DC_FILTER: assert property (
      (ce_i && cfg5[2]) |=> !ch5_channel_config_o.dc_filter_en)
      else $error("ch5 DC filter not disabled");
   AST_CH5_ROUTE: assert property (
      ce_i |=> ($onehot(ch5_input_route_o)
                && ch5_input_route_o.test_neg == ($past(cfg5[1:0]) == 2'h3)))
      else $error("ch5 input route decode wrong");
   AST_CH5_RESETS: assert property (
      $past(sys_rst_i) |-> (reg_q[IDX_CH5_OFS_HI] == RST_ZERO
                            && reg_q[IDX_CH5_OFS_LO] == RST_ZERO
                            && reg_q[IDX_CH5_GAIN_HI] == RST_UNITY_GAIN))
      else $error("ch5 calibration reset values wrong");
   AST_CH5_OFS_LOW_RSVD: assert property (reg_q[IDX_CH5_OFS_LO][7:0] == 8'h00)
      else $error("ch5 offset low reserved bits not zero");
   AST_CH5_GAIN_WRITE: assert property (
      (ce_i && reg_wr_i && reg_addr_i == ADDR_CH5_GAIN_HIGH_WORD)
      |=> (reg_q[IDX_CH5_GAIN_HI] == $past(reg_wdata_i)))
      else $error("ch5 gain high word write lost");
   AST_CH5_OFS_JOIN: assert property (
      ce_i |=> (ch5_cal_o.offset == {$past(reg_q[IDX_CH5_OFS_HI]),
                                     $past(reg_q[IDX_CH5_OFS_LO][15:8])}))
      else $error("ch5 offset word not joined");
   AST_RSVD_READ: assert property (
      (ce_i && reg_rd_i && reg_addr_i == ADDR_CH5_OFFSET_LOW_BYTE)
      |=> (reg_rd_valid_o && reg_rdata_o[7:0] == 8'h00))
      else $error("reserved bits read nonzero");
   AST_FREEZE: assert property (
      (!ce_prev_reg && !$past(sys_rst_i)) |-> $stable(ch4_cal_o) && $stable(reg_rdata_o))
      else $error("state moved while clock enable low");

   COV_GAIN_WRITE: cover property (ce_i && reg_wr_i && reg_addr_i == ADDR_CH5_GAIN_HIGH_WORD);
   COV_FROZEN_WRITE: cover property (!ce_i && reg_wr_i);
   COV_CFG_TEST_NEG: cover property (ce_i && ch5_input_route_o.test_neg);
   COV_UNMAPPED_READ: cover property (reg_rd_valid_o && !reg_hit_o);

endmodule // adc_channel_cal_cfg_regs

// File: adc_channel_cal_cfg_regs_bench.sv
// Self-checking bench for the channel four and five calibration register slice
`timescale 1ns/1ps
module adc_channel_cal_cfg_regs_bench;
   import cal_regs_pkg::*;

   // ----------------------------------------------------------------
   // Signals and expected register map
   // ----------------------------------------------------------------
   logic          clk_i;
   logic          sys_rst_i;
   logic          ce_i;
   logic [5:0]    reg_addr_i;
   logic          reg_wr_i;
   logic          reg_rd_i;
   logic [15:0]   reg_wdata_i;
   logic [15:0]   reg_rdata_o;
   logic          reg_rd_valid_o;
   logic          reg_hit_o;
   logic [15:0]   ch4_offset_high_bits_i;
   logic [7:0]    ch5_gain_low_bits_i;
   logic          global_dc_filter_setting_i;
   cal_word_t     ch4_cal_o;
   cal_word_t     ch5_cal_o;
   ch_cfg_t       ch5_channel_config_o;
   input_route_t  ch5_input_route_o;
   int            fail_count;
   int            comparisons;
   int            cycles;
   logic [15:0]   rdv;
   logic [5:0]    map_addr [0:6] = '{6'h1F, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25};
   logic [15:0]   map_rst  [0:6] = '{16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000,
                                     16'h0000, 16'h8000};
   logic [15:0]   map_mask [0:6] = '{16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7, 16'hFFFF,
                                     16'hFF00, 16'hFFFF};

   adc_channel_cal_cfg_regs DUT (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .reg_rd_valid_o(reg_rd_valid_o), .reg_hit_o(reg_hit_o),
      .ch4_offset_high_bits_i(ch4_offset_high_bits_i),
      .ch5_gain_low_bits_i(ch5_gain_low_bits_i),
      .global_dc_filter_setting_i(global_dc_filter_setting_i),
      .ch4_cal_o(ch4_cal_o), .ch5_cal_o(ch5_cal_o), .ch5_channel_config_o(ch5_channel_config_o),
      .ch5_input_route_o(ch5_input_route_o));

   // ----------------------------------------------------------------
   // Common tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One write strobe, starting one cycle after the call
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_i); #1;
      reg_addr_i = a; reg_wdata_i = d; reg_wr_i = 1'b1;
      @(posedge clk_i); #1;
      reg_wr_i = 1'b0;
   endtask

   // One read strobe; data and hit flag taken in the valid cycle
   task automatic rd(input logic [5:0] a, input logic [15:0] exp, input logic exp_hit);
      @(posedge clk_i); #1;
      reg_addr_i = a; reg_rd_i = 1'b1;
      @(posedge clk_i); #1;
      reg_rd_i = 1'b0;
      chk("reg_rd_valid_o", {47'h0, reg_rd_valid_o}, 48'h1);
      chk("reg_rdata_o", {32'h0, reg_rdata_o}, {32'h0, exp});
      chk("reg_hit_o", {47'h0, reg_hit_o}, {47'h0, exp_hit});
   endtask

   task automatic end_sim;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Reset values of every register, of both calibration words and of the input route
   task automatic t_reset;
      chk("reg_rdata_o", {32'h0, reg_rdata_o}, 48'h0);
      chk("reg_rd_valid_o", {47'h0, reg_rd_valid_o}, 48'h0);
      chk("reg_hit_o", {47'h0, reg_hit_o}, 48'h0);
      for (int i = 0; i < 7; i++) begin
         rd(map_addr[i], map_rst[i], 1'b1);
      end
      chk("ch4_cal_o", ch4_cal_o, 48'hC3A5_0080_0000);
      chk("ch5_cal_o", ch5_cal_o, 48'h0000_0080_0000);
      chk("ch5_input_route_o", {44'h0, ch5_input_route_o}, 48'h8);
   endtask

   // All ones into every register, reserved bits must stay zero
   task automatic t_masks;
      for (int i = 0; i < 7; i++) begin
         wr(map_addr[i], 16'hFFFF);
         rd(map_addr[i], map_mask[i], 1'b1);
      end
      wr(6'h30, 16'hFFFF);
      rd(6'h30, 16'h0000, 1'b0);
      rd(6'h1E, 16'h0000, 1'b0);
   endtask

   // Calibration words joined from high word and low byte
   task automatic t_cal;
      wr(6'h20, 16'h1234);
      wr(6'h21, 16'h56FF);
      wr(6'h1F, 16'h9A77);
      wr(6'h23, 16'hFEDC);
      wr(6'h24, 16'hBA11);
      wr(6'h25, 16'hFFFF);
      ch5_gain_low_bits_i = 8'hFF;
      @(posedge clk_i); #1;
      chk("ch4_cal_o", ch4_cal_o, 48'hC3A5_9A12_3456);
      chk("ch5_cal_o", ch5_cal_o, 48'hFEDC_BAFF_FFFF);
      wr(6'h25, 16'h0000);
      ch5_gain_low_bits_i = 8'h00;
      @(posedge clk_i); #1;
      chk("ch5_cal_o", ch5_cal_o, 48'hFEDC_BA00_0000);
   endtask

   // Every select code, filter disable and global setting
   task automatic t_cfg;
      logic [15:0] d;
      for (int k = 0; k < 16; k++) begin
         d = {10'h200 + 10'(k), 3'b111, k[2], k[1:0]};
         global_dc_filter_setting_i = k[3];
         wr(6'h22, d);
         @(posedge clk_i); #1;
         chk("phase_delay", {38'h0, ch5_channel_config_o.phase_delay}, {38'h0, d[15:6]});
         chk("dc_filter_en", {47'h0, ch5_channel_config_o.dc_filter_en}, {47'h0, k[3] & ~k[2]});
         chk("ch5_input_route_o", {44'h0, ch5_input_route_o}, {44'h0, 4'h8 >> k[1:0]});
         rd(6'h22, d & 16'hFFC7, 1'b1);
      end
   endtask

   // Clock enable low refuses a write and freezes outputs, then a second reset
   task automatic t_freeze;
      @(posedge clk_i); #1;
      ce_i = 1'b0;
      ch4_offset_high_bits_i = 16'h5A5A;
      wr(6'h20, 16'hAAAA);
      @(posedge clk_i); #1;
      chk("ch4_cal_o", ch4_cal_o, 48'hC3A5_9A12_3456);
      ce_i = 1'b1;
      rd(6'h20, 16'h1234, 1'b1);
      chk("ch4_cal_o", ch4_cal_o, 48'h5A5A_9A12_3456);
      ch4_offset_high_bits_i = 16'hC3A5;
      sys_rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         fail_count++;
         end_sim();
      end
   end

   initial begin
      fail_count = 0;
      comparisons = 0;
      cycles = 0;
      sys_rst_i = 1'b1;
      ce_i = 1'b1;
      reg_addr_i = 6'h00;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_wdata_i = 16'h0000;
      ch4_offset_high_bits_i = 16'hC3A5;
      ch5_gain_low_bits_i = 8'h00;
      global_dc_filter_setting_i = 1'b0;
      repeat (16) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      t_reset();
      t_masks();
      t_cal();
      t_cfg();
      t_freeze();
      t_reset();
      end_sim();
   end
endmodule // adc_channel_cal_cfg_regs_bench
